// File: src/aof_pkg.sv
package aof_pkg;

    // Sample and word layout
    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned PRBS_W = 7;
    localparam logic [6:0] PRBS_SEED = 7'h7F;

    // Serial port framing: 8 address bits then 16 data bits
    localparam int unsigned SPI_ADDR_BITS = 8;
    localparam int unsigned SPI_FRAME_BITS = 24;
    localparam int unsigned REG_W = 16;

    // Register addresses (7-bit, address MSB is the write flag)
    localparam logic [6:0] ADDR_CHIP_CONTROL = 7'h04;
    localparam logic [6:0] ADDR_CM_A = 7'h1E;
    localparam logic [6:0] ADDR_RIN_A = 7'h1F;
    localparam logic [6:0] ADDR_CM_B = 7'h3D;
    localparam logic [6:0] ADDR_RIN_B = 7'h3E;
    localparam logic [6:0] ADDR_PATTERN = 7'h63;
    localparam logic [6:0] ADDR_FLAG_CFG = 7'h64;
    localparam logic [6:0] ADDR_DEMUX = 7'h68;

    // Chip control fields
    localparam int unsigned CC_SYNC_SWING_BIT = 8;
    localparam int unsigned CC_TRIG_EN_BIT = 7;
    localparam int unsigned CC_FULL_SWING_BIT = 6;
    localparam int unsigned CC_BANDWIDTH_BIT = 5;
    localparam int unsigned CC_CAL_COLD_BIT = 3;
    localparam logic [15:0] CC_RESET = 16'h0030;
    localparam logic [15:0] CC_WMASK = 16'h01E8;
    localparam logic [15:0] CC_FIXED = 16'h0010;

    // Trim fields
    localparam int unsigned TRIM_W = 5;
    localparam logic [4:0] TRIM_RESET = 5'h10;

    // Flag selector and pattern fields
    localparam int unsigned FU2_SEL_LSB = 2;
    localparam int unsigned FU1_SEL_LSB = 0;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned PAT_W = 2;
    localparam logic [3:0] FLAG_CFG_RESET = 4'h0;
    localparam logic [1:0] PAT_RESET = 2'h0;
    localparam logic DEMUX_RESET = 1'b0;

    // Back-pressure margin covering the input delay line and ready register
    localparam int unsigned FIFO_MARGIN = 5;

    typedef enum logic [1:0] {
        SEL_IN_RANGE = 2'b00,
        SEL_PARITY = 2'b01,
        SEL_TRIGGER = 2'b10,
        SEL_UNUSED = 2'b11
    } aof_sel_e;

    typedef enum logic [1:0] {
        PAT_DATA = 2'b00,
        PAT_XOR = 2'b01,
        PAT_UNUSED = 2'b10,
        PAT_ONLY = 2'b11
    } aof_pat_e;

    typedef struct packed {
        logic trig;
        logic sat_b;
        logic [SAMPLE_W-1:0] b;
        logic sat_a;
        logic [SAMPLE_W-1:0] a;
    } aof_word_s;

endpackage : aof_pkg

// File: src/aof_formatter.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module aof_fifo #(
    parameter int unsigned WIDTH = 27,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } aof_fifo_s;

    aof_fifo_s st;
    aof_fifo_s next_st;
    logic push;
    logic pop;

    // Honest flags straight from the count
    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
    assign level = st.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : aof_fifo

////////////////////////////////////////////////////////////////////////////////
module aof_formatter #(
    parameter int unsigned FIFO_DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [11:0] chan_a_sample,
    input wire logic chan_a_saturated,
    input wire logic [11:0] chan_b_sample,
    input wire logic chan_b_saturated,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic sync_or_trigger_input,
    input wire logic link_ready,
    output logic [11:0] out_a_hi,
    output logic [11:0] out_a_lo,
    output logic [11:0] out_b_hi,
    output logic [11:0] out_b_lo,
    output logic flag_bit_one_a,
    output logic flag_bit_two_a,
    output logic flag_bit_one_b,
    output logic flag_bit_two_b,
    output logic data_ready,
    output logic sync_reset_pulse,
    output logic trigger_mode,
    output logic output_full_swing_bit,
    output logic sync_out_full_swing,
    output logic bandwidth_nominal_bit,
    output logic temp_cal_cold,
    output logic [4:0] chan_a_common_mode_trim,
    output logic [4:0] chan_a_impedance_trim,
    output logic [4:0] chan_b_common_mode_trim,
    output logic [4:0] chan_b_impedance_trim
);
    localparam int unsigned WW = $bits(aof_pkg::aof_word_s);
    localparam int unsigned RW = WW - 1;

    typedef struct packed {
        logic [1:0] sclk_sy;
        logic [1:0] csn_sy;
        logic [1:0] mosi_sy;
        logic [1:0] rdy_sy;
        logic [1:0] sync_sy;
        logic sclk_prev;
        logic sync_prev;
        logic [4:0] bit_cnt;
        logic [23:0] shift;
        logic [15:0] rd_shift;
        logic miso;
        logic miso_oe;
        logic [15:0] chip_ctrl;
        logic [4:0] cm_a;
        logic [4:0] rin_a;
        logic [4:0] cm_b;
        logic [4:0] rin_b;
        logic [1:0] pat;
        logic [3:0] fu_cfg;
        logic dmux;
        logic [1:0][RW-1:0] d_word;
        logic [1:0] d_valid;
        logic s_ready;
        aof_pkg::aof_word_s hold;
        logic hold_v;
        logic [6:0] lfsr;
        logic [11:0] a_hi;
        logic [11:0] a_lo;
        logic [11:0] b_hi;
        logic [11:0] b_lo;
        logic [3:0] flags;
        logic drdy;
        logic sync_pulse;
    } aof_state_s;

    aof_state_s st;
    aof_state_s next_st;
    aof_pkg::aof_word_s fifo_in;
    aof_pkg::aof_word_s fifo_out;
    aof_pkg::aof_word_s hi_w;
    aof_pkg::aof_word_s lo_w;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic pop;
    logic emit;
    logic prbs_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux; unmapped addresses read zero
    function automatic logic [15:0] reg_read(input aof_state_s s, input logic [6:0] a);
        logic [15:0] v;
        v = '0;
        unique case (a)
            aof_pkg::ADDR_CHIP_CONTROL: v = s.chip_ctrl;
            aof_pkg::ADDR_CM_A: v = {11'h000, s.cm_a};
            aof_pkg::ADDR_RIN_A: v = {11'h000, s.rin_a};
            aof_pkg::ADDR_CM_B: v = {11'h000, s.cm_b};
            aof_pkg::ADDR_RIN_B: v = {11'h000, s.rin_b};
            aof_pkg::ADDR_PATTERN: v = {14'h0000, s.pat};
            aof_pkg::ADDR_FLAG_CFG: v = {12'h000, s.fu_cfg};
            aof_pkg::ADDR_DEMUX: v = {15'h0000, s.dmux};
            default: v = '0;
        endcase
        return v;
    endfunction : reg_read

    // Flag value for one selector on one channel sample
    function automatic logic flag_val(input logic [1:0] sel, input logic sat, input logic [11:0] d,
                                      input logic trig, input logic trigger_enable_bit);
        logic f;
        f = 1'b0;
        unique case (aof_pkg::aof_sel_e'(sel))
            aof_pkg::SEL_IN_RANGE: f = ~sat;
            aof_pkg::SEL_PARITY: f = ^d;
            aof_pkg::SEL_TRIGGER: f = trig & trigger_enable_bit;
            aof_pkg::SEL_UNUSED: f = 1'b0;
        endcase
        return f;
    endfunction : flag_val

    // Pattern stage on data plus two flags
    function automatic logic [13:0] apply_pat(input logic [1:0] pat, input logic [13:0] v, input logic pb);
        logic [13:0] r;
        r = v;
        unique case (aof_pkg::aof_pat_e'(pat))
            aof_pkg::PAT_DATA: r = v;
            aof_pkg::PAT_XOR: r = v ^ {14{pb}};
            aof_pkg::PAT_UNUSED: r = v;
            aof_pkg::PAT_ONLY: r = {14{pb}};
        endcase
        return r;
    endfunction : apply_pat

    ////////////////////////////////////////////////////////////////////////////
    // Sample buffer between the delay line and the output formatter
    assign fifo_in = {st.sync_sy[1], st.d_word[1]};
    assign pop = fifo_out_valid && st.rdy_sy[1];
    assign prbs_bit = st.lfsr[6];

    aof_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rstn(rstn),
        .in_valid(st.d_valid[1]),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(st.rdy_sy[1]),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: serial port, delay line, output formatter
    always_comb begin
        logic [23:0] full;
        logic rise;
        logic fall;
        logic [13:0] a_hi_v;
        logic [13:0] b_hi_v;
        logic [13:0] a_lo_v;
        logic [13:0] b_lo_v;
        logic trigger_enable_bit;
        full = '0;
        rise = 1'b0;
        fall = 1'b0;
        a_hi_v = '0;
        b_hi_v = '0;
        a_lo_v = '0;
        b_lo_v = '0;
        next_st = st;
        hi_w = fifo_out;
        lo_w = '0;
        emit = 1'b0;
        trigger_enable_bit = st.chip_ctrl[aof_pkg::CC_TRIG_EN_BIT];

        // Pin synchronisers, stage 0 only feeds stage 1
        next_st.sclk_sy = {st.sclk_sy[0], spi_sclk};
        next_st.csn_sy = {st.csn_sy[0], spi_csn};
        next_st.mosi_sy = {st.mosi_sy[0], spi_mosi};
        next_st.rdy_sy = {st.rdy_sy[0], link_ready};
        next_st.sync_sy = {st.sync_sy[0], sync_or_trigger_input};
        next_st.sclk_prev = st.sclk_sy[1];
        next_st.sync_prev = st.sync_sy[1];
        rise = st.sclk_sy[1] & ~st.sclk_prev;
        fall = ~st.sclk_sy[1] & st.sclk_prev;
        full = {st.shift[22:0], st.mosi_sy[1]};

        // Serial register port, mode 0
        if (st.csn_sy[1]) begin
            next_st.bit_cnt = '0;
            next_st.miso_oe = 1'b0;
        end else begin
            next_st.miso_oe = 1'b1;
            if (rise && st.bit_cnt != 5'(aof_pkg::SPI_FRAME_BITS)) begin
                next_st.shift = full;
                next_st.bit_cnt = st.bit_cnt + 5'h01;
                if (st.bit_cnt == 5'(aof_pkg::SPI_ADDR_BITS - 1) && !full[7]) begin
                    next_st.rd_shift = reg_read(st, full[6:0]);
                end
                if (st.bit_cnt == 5'(aof_pkg::SPI_FRAME_BITS - 1) && full[23]) begin
                    unique case (full[22:16])
                        aof_pkg::ADDR_CHIP_CONTROL: next_st.chip_ctrl = (full[15:0] & aof_pkg::CC_WMASK)
                                                                  | aof_pkg::CC_FIXED;
                        aof_pkg::ADDR_CM_A: next_st.cm_a = full[4:0];
                        aof_pkg::ADDR_RIN_A: next_st.rin_a = full[4:0];
                        aof_pkg::ADDR_CM_B: next_st.cm_b = full[4:0];
                        aof_pkg::ADDR_RIN_B: next_st.rin_b = full[4:0];
                        aof_pkg::ADDR_PATTERN: next_st.pat = full[1:0];
                        aof_pkg::ADDR_FLAG_CFG: next_st.fu_cfg = full[3:0];
                        aof_pkg::ADDR_DEMUX: next_st.dmux = full[0];
                        default: next_st.dmux = st.dmux;
                    endcase
                end
            end
            if (fall && st.bit_cnt >= 5'(aof_pkg::SPI_ADDR_BITS)) begin
                next_st.miso = st.rd_shift[15];
                next_st.rd_shift = {st.rd_shift[14:0], 1'b0};
            end
        end

        // Data delay equal to the trigger synchroniser depth
        next_st.d_word = {st.d_word[0], chan_b_saturated, chan_b_sample, chan_a_saturated, chan_a_sample};
        next_st.d_valid = {st.d_valid[0], sample_valid & st.s_ready};
        next_st.s_ready = (fifo_level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - aof_pkg::FIFO_MARGIN));

        // Synchronisation event only outside trigger mode
        next_st.sync_pulse = st.sync_sy[1] & ~st.sync_prev & ~trigger_enable_bit;

        // Word assembly
        if (!st.dmux) begin
            next_st.hold_v = 1'b0;
            emit = pop;
        end else if (pop) begin
            if (!st.hold_v) begin
                next_st.hold = fifo_out;
                next_st.hold_v = 1'b1;
            end else begin
                hi_w = st.hold;
                lo_w = fifo_out;
                next_st.hold_v = 1'b0;
                emit = 1'b1;
            end
        end

        // Flags share selectors across channels and travel with the sample
        a_hi_v[11:0] = hi_w.a;
        b_hi_v[11:0] = hi_w.b;
        a_hi_v[12] = flag_val(st.fu_cfg[1:0], hi_w.sat_a, hi_w.a, hi_w.trig, trigger_enable_bit);
        b_hi_v[12] = flag_val(st.fu_cfg[1:0], hi_w.sat_b, hi_w.b, hi_w.trig, trigger_enable_bit);
        a_lo_v[11:0] = lo_w.a;
        b_lo_v[11:0] = lo_w.b;
        if (!st.dmux) begin
            a_hi_v[13] = flag_val(st.fu_cfg[3:2], hi_w.sat_a, hi_w.a, hi_w.trig, trigger_enable_bit);
            b_hi_v[13] = flag_val(st.fu_cfg[3:2], hi_w.sat_b, hi_w.b, hi_w.trig, trigger_enable_bit);
        end else begin
            a_hi_v[13] = flag_val(st.fu_cfg[3:2], lo_w.sat_a, lo_w.a, lo_w.trig, trigger_enable_bit);
            b_hi_v[13] = flag_val(st.fu_cfg[3:2], lo_w.sat_b, lo_w.b, lo_w.trig, trigger_enable_bit);
        end

        // Output register and generator step
        if (emit) begin
            a_hi_v = apply_pat(st.pat, a_hi_v, prbs_bit);
            b_hi_v = apply_pat(st.pat, b_hi_v, prbs_bit);
            a_lo_v = st.dmux ? apply_pat(st.pat, {2'b00, lo_w.a}, prbs_bit) : '0;
            b_lo_v = st.dmux ? apply_pat(st.pat, {2'b00, lo_w.b}, prbs_bit) : '0;
            next_st.a_hi = a_hi_v[11:0];
            next_st.b_hi = b_hi_v[11:0];
            next_st.a_lo = a_lo_v[11:0];
            next_st.b_lo = b_lo_v[11:0];
            next_st.flags = {b_hi_v[13], b_hi_v[12], a_hi_v[13], a_hi_v[12]};
            next_st.lfsr = {st.lfsr[5:0], st.lfsr[6] ^ st.lfsr[5]};
        end
        next_st.drdy = emit;
    end

    // State register with documented reset values
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.sclk_sy <= 2'h3;
            st.csn_sy <= 2'h3;
            st.sclk_prev <= 1'b1;
            st.chip_ctrl <= aof_pkg::CC_RESET;
            st.cm_a <= aof_pkg::TRIM_RESET;
            st.rin_a <= aof_pkg::TRIM_RESET;
            st.cm_b <= aof_pkg::TRIM_RESET;
            st.rin_b <= aof_pkg::TRIM_RESET;
            st.pat <= aof_pkg::PAT_RESET;
            st.fu_cfg <= aof_pkg::FLAG_CFG_RESET;
            st.dmux <= aof_pkg::DEMUX_RESET;
            st.lfsr <= aof_pkg::PRBS_SEED;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign spi_miso = st.miso;
    assign spi_miso_oe = st.miso_oe;
    assign sample_ready = st.s_ready;
    assign out_a_hi = st.a_hi;
    assign out_a_lo = st.a_lo;
    assign out_b_hi = st.b_hi;
    assign out_b_lo = st.b_lo;
    assign {flag_bit_two_b, flag_bit_one_b, flag_bit_two_a, flag_bit_one_a} = st.flags;
    assign data_ready = st.drdy;
    assign sync_reset_pulse = st.sync_pulse;
    assign trigger_mode = st.chip_ctrl[aof_pkg::CC_TRIG_EN_BIT];
    assign output_full_swing_bit = st.chip_ctrl[aof_pkg::CC_FULL_SWING_BIT];
    assign sync_out_full_swing = st.chip_ctrl[aof_pkg::CC_SYNC_SWING_BIT];
    assign bandwidth_nominal_bit = st.chip_ctrl[aof_pkg::CC_BANDWIDTH_BIT];
    assign temp_cal_cold = st.chip_ctrl[aof_pkg::CC_CAL_COLD_BIT];
    assign chan_a_common_mode_trim = st.cm_a;
    assign chan_a_impedance_trim = st.rin_a;
    assign chan_b_common_mode_trim = st.cm_b;
    assign chan_b_impedance_trim = st.rin_b;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_plain_emit;
        emit && st.pat == 2'b00;
    endsequence

    sequence s_pair_done;
        st.dmux && pop && !st.hold_v ##1 st.dmux && pop;
    endsequence

    property p_in_range;
        @(posedge ref_clk) disable iff (!rstn)
        s_plain_emit and (st.fu_cfg[1:0] == 2'b00) |=> flag_bit_one_a == ~$past(hi_w.sat_a);
    endproperty
    a_in_range: assert property (p_in_range) else $error("in-range flag wrong");

    property p_parity_lo;
        @(posedge ref_clk) disable iff (!rstn)
        s_plain_emit and (st.dmux && st.fu_cfg[3:2] == 2'b01) |=> flag_bit_two_b == ^$past(lo_w.b);
    endproperty
    a_parity_lo: assert property (p_parity_lo) else $error("low-port parity flag wrong");

    property p_trigger;
        @(posedge ref_clk) disable iff (!rstn)
        s_plain_emit and (st.fu_cfg[1:0] == 2'b10) |=>
            flag_bit_one_b == ($past(hi_w.trig) & $past(trigger_mode));
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger flag wrong");

    property p_same_sample;
        @(posedge ref_clk) disable iff (!rstn)
        s_plain_emit and (!st.dmux && st.fu_cfg[1:0] == st.fu_cfg[3:2]) |=>
            flag_bit_one_a == flag_bit_two_a && flag_bit_one_b == flag_bit_two_b;
    endproperty
    a_same_sample: assert property (p_same_sample) else $error("flags differ in one-to-one");

    property p_pass;
        @(posedge ref_clk) disable iff (!rstn)
        s_plain_emit |=> out_a_hi == $past(hi_w.a) && out_b_hi == $past(hi_w.b) && data_ready;
    endproperty
    a_pass: assert property (p_pass) else $error("unmodified data wrong");

    property p_scramble;
        @(posedge ref_clk) disable iff (!rstn)
        emit && st.pat == 2'b01 |=> (out_a_hi ^ $past(hi_w.a)) == {12{$past(prbs_bit)}};
    endproperty
    a_scramble: assert property (p_scramble) else $error("scrambled data wrong");

    property p_prbs_only;
        @(posedge ref_clk) disable iff (!rstn)
        emit && st.pat == 2'b11 |=> out_b_hi == {12{flag_bit_one_a}} && flag_bit_two_b == flag_bit_one_a
            && flag_bit_one_a == $past(prbs_bit);
    endproperty
    a_prbs_only: assert property (p_prbs_only) else $error("pattern-only output wrong");

    property p_lfsr;
        @(posedge ref_clk) disable iff (!rstn)
        emit |=> st.lfsr == {$past(st.lfsr[5:0]), $past(st.lfsr[6]) ^ $past(st.lfsr[5])};
    endproperty
    a_lfsr: assert property (p_lfsr) else $error("generator step wrong");

    property p_half_rate;
        @(posedge ref_clk) disable iff (!rstn)
        s_pair_done |-> ##1 data_ready ##1 !data_ready;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("pair not emitted once");

    property p_lo_zero;
        @(posedge ref_clk) disable iff (!rstn)
        emit && !st.dmux |=> out_a_lo == 12'h000 && out_b_lo == 12'h000;
    endproperty
    a_lo_zero: assert property (p_lo_zero) else $error("low port not idle in one-to-one");
endmodule : aof_formatter

// File: sim/aof_capture_model.sv
`timescale 1ns/1ps
// Capturing side: stalls on request, counts words
module aof_capture_model (
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic data_ready,
    output logic link_ready,
    output int words
);
    // Ready is the inverse of stall, one word counted per cycle with data_ready high
    initial begin
        link_ready = 1;
        words = 0;
    end
    always @(posedge ref_clk) begin
        link_ready <= #1 !stall;
        words <= words + (data_ready === 1'b1);
    end
endmodule : aof_capture_model

// File: sim/test_aof_formatter.sv
`timescale 1ns/1ps
module test_aof_formatter;
    logic ref_clk = 0, rstn = 0, spi_sclk = 0, spi_csn = 1, spi_mosi = 0, sample_valid = 0, stall = 0;
    logic chan_a_saturated = 0, chan_b_saturated = 0, sync_or_trigger_input = 0, link_ready, sample_ready;
    logic [11:0] chan_a_sample = 0, chan_b_sample = 0, out_a_hi, out_a_lo, out_b_hi, out_b_lo;
    logic spi_miso, data_ready, flag_bit_one_a, flag_bit_two_a, flag_bit_one_b, flag_bit_two_b;
    logic trigger_mode, output_full_swing_bit, bandwidth_nominal_bit, sync_out_full_swing, temp_cal_cold;
    logic spi_miso_oe, sync_reset_pulse;
    logic [4:0] chan_a_common_mode_trim, chan_a_impedance_trim, chan_b_common_mode_trim, chan_b_impedance_trim;
    logic [15:0] q;
    logic [3:0] flags;
    int err_count = 0, checks = 0, words, n, k, w0, pulses = 0;
    ////////////////////////////////////////
    // Clock, device and capturer
    always #2 ref_clk = !ref_clk;
    aof_formatter #(.FIFO_DEPTH(32)) dut (.ref_clk, .rstn, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso,
        .spi_miso_oe, .chan_a_sample, .chan_a_saturated, .chan_b_sample, .chan_b_saturated, .sample_valid,
        .sample_ready, .sync_or_trigger_input, .link_ready, .out_a_hi, .out_a_lo, .out_b_hi, .out_b_lo,
        .flag_bit_one_a, .flag_bit_two_a, .flag_bit_one_b, .flag_bit_two_b, .data_ready, .sync_reset_pulse,
        .trigger_mode, .output_full_swing_bit, .sync_out_full_swing, .bandwidth_nominal_bit,
        .temp_cal_cold, .chan_a_common_mode_trim, .chan_a_impedance_trim, .chan_b_common_mode_trim,
        .chan_b_impedance_trim);
    aof_capture_model cap (.ref_clk, .stall, .data_ready, .link_ready, .words);
    assign flags = {flag_bit_one_a, flag_bit_two_a, flag_bit_one_b, flag_bit_two_b};
    // Count synchronisation pulses
    always @(posedge ref_clk) begin
        if (sync_reset_pulse === 1'b1) begin
            pulses++;
        end
    end
    ////////////////////////////////////////
    // Bench tasks
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input string s, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    // Serial frame, read data collected in q
    task automatic spi(input logic [23:0] f);
        spi_csn = 0;
        tick(4);
        chk("miso_oe", spi_miso_oe, 1);
        for (int i = 23; i >= 0; i--) begin
            spi_mosi = f[i];
            tick(4);
            q = {q[14:0], spi_miso};
            spi_sclk = 1;
            tick(4);
            spi_sclk = 0;
        end
        tick(8);
        spi_csn = 1;
        tick(8);
        chk("miso_oe idle", spi_miso_oe, 0);
    endtask : spi
    task automatic push(input logic [11:0] a, input logic [11:0] b, input logic sa, input logic sb);
        {chan_a_sample, chan_b_sample, chan_a_saturated, chan_b_saturated} = {a, b, sa, sb};
        sample_valid = 1;
        tick(1);
    endtask : push
    task automatic await;
        sample_valid = 0;
        for (n = 0; n < 50 && data_ready !== 1'b1; n++) tick(1);
        chk("data_ready", data_ready, 1);
    endtask : await
    task automatic close_out;
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////
    // Watchdog
    initial begin
        #200000;
        err_count++;
        close_out;
    end
    // Main sequence
    initial begin
        tick(12);
        rstn = 1;
        tick(4);
        chk("trims reset", {chan_a_impedance_trim, chan_b_common_mode_trim}, {5'h10, 5'h10});
        sync_or_trigger_input = 1;
        tick(6);
        sync_or_trigger_input = 0;
        chk("sync pulse", pulses, 1);
        spi(24'h040000);
        chk("chip_control", q, 16'h0030);
        spi(24'h1E0000);
        chk("cm_a", q, 16'h0010);
        spi(24'h3E0000);
        chk("rin_b", q, 16'h0010);
        spi(24'h640000);
        chk("flag_cfg", q, 16'h0000);
        spi(24'h680000);
        chk("demux", q, 16'h0000);
        spi(24'h010000);
        chk("unmapped", q, 16'h0000);
        spi(24'h9E001F);
        chk("cm_a port", chan_a_common_mode_trim, 5'h1F);
        spi(24'hBE0007);
        chk("rin_b port", chan_b_impedance_trim, 5'h07);
        spi(24'h84FFFF);
        chk("cc ports", {trigger_mode, output_full_swing_bit, bandwidth_nominal_bit}, 3'h7);
        chk("cc extra", {sync_out_full_swing, temp_cal_cold}, 2'h3);
        spi(24'h040000);
        chk("chip_control", q, 16'h01F8);
        spi(24'hE3FFFF);
        spi(24'h630000);
        chk("pattern", q, 16'h0003);
        spi(24'hE30000);
        spi(24'hE40001);
        push(12'hA53, 12'h001, 1, 0);
        await;
        chk("one to one", {out_a_hi, out_a_lo, out_b_hi, out_b_lo}, 48'hA53000001000);
        chk("flags", flags, 4'h3);
        spi(24'hE80001);
        spi(24'hE40005);
        push(12'h001, 12'h003, 0, 0);
        push(12'h003, 12'h001, 0, 0);
        await;
        chk("pair", {out_a_hi, out_a_lo, out_b_hi, out_b_lo}, 48'h001003003001);
        chk("pair flags", flags, 4'h9);
        spi(24'hE80000);
        spi(24'hE4000A);
        sync_or_trigger_input = 1;
        tick(8);
        push(12'h000, 12'h000, 0, 0);
        await;
        chk("trigger", {flag_bit_one_a, flag_bit_two_b}, 2'h3);
        chk("no sync pulse", pulses, 1);
        spi(24'hE30003);
        push(12'h5A5, 12'h0F0, 0, 1);
        await;
        chk("prbs only", {out_a_hi, out_b_hi, flag_bit_one_a, flag_bit_two_b}, {24'hFFFFFF, 2'h3});
        spi(24'hE30001);
        spi(24'hE40001);
        push(12'h5A5, 12'h000, 0, 0);
        await;
        chk("scramble", {out_a_hi, flag_bit_one_a}, {12'hA5A, 1'b1});
        spi(24'hE30002);
        spi(24'hE4000F);
        push(12'h5A5, 12'h000, 0, 0);
        await;
        chk("unsupported", {out_a_hi, flags}, {12'h5A5, 4'h0});
        spi(24'hE30000);
        spi(24'hE40004);
        stall = 1;
        tick(8);
        w0 = words;
        for (k = 0; k < 40 && sample_ready === 1'b1; k++) push(12'(k), 12'(k), 0, 0);
        sample_valid = 0;
        chk("full", sample_ready, 0);
        stall = 0;
        tick(200);
        chk("drained", words - w0, k);
        close_out;
    end
endmodule : test_aof_formatter
